/* core/wwts_pkg.sv */
`default_nettype none
package wwts_pkg;
	localparam int unsigned CLK_MHZ          = 200;
	// Base times in microseconds
	localparam int unsigned DETECT_US        = 381;
	localparam int unsigned DETECT_CYC       = DETECT_US * CLK_MHZ;
	// Timebase tick: 1 us
	localparam int unsigned TICK_CYC         = CLK_MHZ;
	// Delay values in tenths of a microsecond are avoided: all in us ticks
	localparam int unsigned RST_OPEN_US      = 200_000;
	localparam int unsigned RST_PULL_US      = 10_000;
	localparam int unsigned RST_MIN_US       = 700;
	localparam int unsigned RST_MAX_US       = 3_200_000;
	localparam int unsigned RST_OFS_US       = 381;
	// Capacitor slope: us per 100 us of charge (3.22 s per uF)
	localparam int unsigned RST_SLOPE_X100   = 322;
	localparam int unsigned WIN_SLOPE_X10    = 774;
	localparam int unsigned WIN_OFS_US       = 55_000;
	localparam int unsigned OPEN_L00_US      = 22_500;
	localparam int unsigned OPEN_U00_US      = 55_000;
	localparam int unsigned OPEN_L01_US      = 1_850;
	localparam int unsigned OPEN_U01_US      = 27_500;
	localparam int unsigned OPEN_L11_US      = 800_000;
	localparam int unsigned OPEN_U11_US      = 1_600_000;
	localparam int unsigned PULL_L00_US      = 9_000;
	localparam int unsigned PULL_U00_US      = 109_000;
	localparam int unsigned PULL_L01_US      = 9_000;
	localparam int unsigned PULL_U01_US      = 195_000;
	localparam int unsigned PULL_L11_US      = 1_850;
	localparam int unsigned PULL_U11_US      = 11_000;
	localparam int unsigned TW               = 28;
	typedef enum logic [1:0] {STRAP_OPEN, STRAP_PULL, STRAP_CAP} wwts_strap_t;
endpackage
`default_nettype wire

/* core/wwts_cfg_if.sv */
`default_nettype none
interface wwts_cfg_if;
	import wwts_pkg::*;
	logic        [TW-1:0] lowerTicks;
	logic        [TW-1:0] upperTicks;
	logic        [TW-1:0] delayTicks;
	logic                 disabled;
	modport src (output lowerTicks, upperTicks, delayTicks, disabled);
	modport dst (input lowerTicks, upperTicks, delayTicks, disabled);
endinterface
`default_nettype wire

/* core/wwts_timing_calc.sv */
`default_nettype none
module wwts_timing_calc
	import wwts_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        load,
	input  wire wwts_strap_t rstStrap,
	input  wire wwts_strap_t winStrap,
	input  wire logic [23:0] rstCapUs,
	input  wire logic [23:0] winCapUs,
	input  wire logic        ratioSelect0,
	input  wire logic        ratioSelect1,
	wwts_cfg_if.src          cfg
);
	logic [TW-1:0] lowD, upD, dlyD;
	logic [TW+3:0] capUp;
	always_comb begin
		// Capacitor charge time scaled by slope; offsets keep the documented intercepts
		dlyD  = (rstStrap == STRAP_OPEN) ? TW'(RST_OPEN_US) :
		        (rstStrap == STRAP_PULL) ? TW'(RST_PULL_US) :
		        TW'((32'(rstCapUs) * RST_SLOPE_X100) / 100 + RST_OFS_US);
		if (rstStrap == STRAP_CAP && dlyD < TW'(RST_MIN_US))
			dlyD = TW'(RST_MIN_US);
		if (rstStrap == STRAP_CAP && dlyD > TW'(RST_MAX_US))
			dlyD = TW'(RST_MAX_US);
		capUp = (TW+4)'((32'(winCapUs) * WIN_SLOPE_X10) / 10 + WIN_OFS_US);
		unique case ({winStrap == STRAP_CAP, winStrap == STRAP_PULL, ratioSelect0, ratioSelect1})
			4'b0000: begin lowD = TW'(OPEN_L00_US); upD = TW'(OPEN_U00_US); end
			4'b0001: begin lowD = TW'(OPEN_L01_US); upD = TW'(OPEN_U01_US); end
			4'b0011: begin lowD = TW'(OPEN_L11_US); upD = TW'(OPEN_U11_US); end
			4'b0100: begin lowD = TW'(PULL_L00_US); upD = TW'(PULL_U00_US); end
			4'b0101: begin lowD = TW'(PULL_L01_US); upD = TW'(PULL_U01_US); end
			4'b0111: begin lowD = TW'(PULL_L11_US); upD = TW'(PULL_U11_US); end
			4'b1000: begin upD = capUp[TW-1:0]; lowD = upD >> 3; end
			4'b1001: begin upD = capUp[TW-1:0]; lowD = TW'((upD * 3) >> 2); end
			4'b1011: begin upD = capUp[TW-1:0]; lowD = upD >> 1; end
			default: begin lowD = '0; upD = '0; end
		endcase
	end
	always_ff @(posedge clk) begin
		if (load) begin
			cfg.lowerTicks <= lowD;
			cfg.upperTicks <= upD;
			cfg.delayTicks <= dlyD;
			cfg.disabled   <= ratioSelect0 & ~ratioSelect1;
		end
	end
endmodule
`default_nettype wire

/* core/wwts_watchdog.sv */
// Notes on behaviour
// - Strap detection by pulldown, done in 381 us
// - Re-detect straps on every fault assertion
// - Open delay 200 ms, pull-up 10 ms
// - Capacitor delay spans 700 us to 3.2 s
// - Cap delay = 3.22*C + 0.000381 s
// - Cap delay within documented min/max lines
// - Discharge during fault, charge after, release
// - Open/pull-up window pin: factory windows
// - Open window pin boundary table
// - Pulled-up window pin boundary table
// - Cap upper bound = 77.4*C + 0.055 s
// - Cap upper bound within 0.905..1.095 typ
// - Cap lower bound = upper times ratio
// - Select 10 disables watchdog entirely
// - Kick outside window asserts fault
// - Kicks ignored while fault asserted
// - Select changes latch only at strap detection, after reset or a fault
`default_nettype none
module wwts_watchdog
	import wwts_pkg::*;
#(
	parameter int unsigned DETECT_CYCLES = DETECT_CYC,
	parameter int unsigned TICK_CYCLES   = TICK_CYC
)(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic kickInput,
	input  wire logic ratioSelect0,
	input  wire logic ratioSelect1,
	// Sensed pin levels: high while pulldown off/on, cap charged comparator
	input  wire logic resetDelayPinIn,
	input  wire logic resetDelayPinCharged,
	input  wire logic windowTimePinIn,
	input  wire logic windowTimePinCharged,
	// Measured charge times of attached capacitors, in us of the formula slope
	input  wire logic [23:0] resetDelayCapUs,
	input  wire logic [23:0] windowCapUs,
	output logic      resetDelayPulldown,
	output logic      resetDelayCharge,
	output logic      windowTimePulldown,
	output logic      faultOutput_n,
	output logic      faultOutputOe_n,
	output logic      detectDone
);
	// Detection needs a count and a compare cycle; the tick divider needs at least one cycle
	if (DETECT_CYCLES < 2 || TICK_CYCLES < 1) begin : g_badTiming
		$error("wwts_watchdog: bad timing parameters");
	end

	typedef enum logic [2:0] {ST_DETECT, ST_LOAD, ST_FIRST, ST_WINDOW, ST_FAULT, ST_OFF} wwts_state_t;

	wwts_cfg_if cfg ();

	wwts_state_t state_q, state_d;
	logic [31:0] detCnt_q, detCnt_d;
	logic [31:0] tickCnt_q, tickCnt_d;
	logic [TW-1:0] time_q, time_d;
	logic        kickDly_q;
	wwts_strap_t rstStrap_q, rstStrap_d, winStrap_q, winStrap_d;
	logic        pd_q, pd_d, chg_q, chg_d, fault_q, fault_d, done_q, done_d;
	logic        pdOut_q, pdOut_d, oeN_q, oeN_d;
	logic        tick, kickFall, load;

	assign tick     = (tickCnt_q == TICK_CYCLES - 1);
	assign kickFall = kickDly_q & ~kickInput;
	assign load     = (state_q == ST_LOAD);

	wwts_timing_calc u_calc (
		.clk          (clk),
		.load         (load),
		.rstStrap     (rstStrap_q),
		.winStrap     (winStrap_q),
		.rstCapUs     (resetDelayCapUs),
		.winCapUs     (windowCapUs),
		.ratioSelect0 (ratioSelect0),
		.ratioSelect1 (ratioSelect1),
		.cfg          (cfg.src)
	);

	function automatic wwts_strap_t classify(input logic lvl, input logic chg);
		// Pulldown on: a 10k pull-up still reads high; open or cap reads low
		if (lvl)
			return STRAP_PULL;
		else if (chg)
			return STRAP_CAP;
		else
			return STRAP_OPEN;
	endfunction

	always_comb begin
		state_d    = state_q;
		detCnt_d   = detCnt_q;
		tickCnt_d  = tick ? '0 : tickCnt_q + 32'd1;
		time_d     = time_q;
		rstStrap_d = rstStrap_q;
		winStrap_d = winStrap_q;
		pd_d       = pd_q;
		chg_d      = chg_q;
		fault_d    = fault_q;
		done_d     = done_q;
		if (tick && time_q != '0)
			time_d = time_q - TW'(1);
		unique case (state_q)
			ST_DETECT: begin
				pd_d     = 1'b1;
				detCnt_d = detCnt_q + 32'd1;
				if (detCnt_q == DETECT_CYCLES - 1) begin
					rstStrap_d = classify(resetDelayPinIn, resetDelayPinCharged);
					winStrap_d = classify(windowTimePinIn, windowTimePinCharged);
					pd_d       = 1'b0;
					state_d    = ST_LOAD;
				end
			end
			ST_LOAD: begin
				done_d  = 1'b1;
				state_d = fault_q ? ST_FAULT : ST_FIRST;
				// Delay count is loaded one cycle later from the fresh latch
			end
			ST_FIRST: begin
				if (cfg.disabled) begin
					state_d = ST_OFF;
				end else if (kickFall) begin
					// First kick only needs to beat the upper bound
					time_d  = cfg.upperTicks;
					state_d = ST_WINDOW;
				end else if (time_q == '0) begin
					fault_d  = 1'b1;
					state_d  = ST_DETECT;
					detCnt_d = '0;
				end
			end
			ST_WINDOW: begin
				if (kickFall) begin
					if (time_q > cfg.upperTicks - cfg.lowerTicks) begin
						fault_d  = 1'b1;
						state_d  = ST_DETECT;
						detCnt_d = '0;
					end else begin
						time_d  = cfg.upperTicks;
						state_d = ST_WINDOW;
					end
				end else if (time_q == '0) begin
					fault_d  = 1'b1;
					state_d  = ST_DETECT;
					detCnt_d = '0;
				end
			end
			ST_FAULT: begin
				// Kicks are not examined here at all
				chg_d = 1'b1;
				if (!chg_q)
					time_d = cfg.delayTicks;
				else if ((rstStrap_q == STRAP_CAP && resetDelayPinCharged) ||
				         (rstStrap_q != STRAP_CAP && time_q == '0)) begin
					fault_d = 1'b0;
					chg_d   = 1'b0;
					state_d = ST_FIRST;
					time_d  = cfg.upperTicks; // First-kick timeout starts at release
				end
			end
			ST_OFF: begin
				fault_d = 1'b0;
			end
			default: state_d = ST_DETECT;
		endcase
		// Registered so the pin drivers never glitch on decode
		pdOut_d = pd_d | (fault_d & ~chg_d);
		oeN_d   = ~fault_d;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q    <= ST_DETECT;
			detCnt_q   <= '0;
			tickCnt_q  <= '0;
			time_q     <= '0;
			kickDly_q  <= 1'b1;
			rstStrap_q <= STRAP_OPEN;
			winStrap_q <= STRAP_OPEN;
			pd_q       <= 1'b0;
			chg_q      <= 1'b0;
			fault_q    <= 1'b1; // Power-up reset delay counts as a fault period
			done_q     <= 1'b0;
			pdOut_q    <= 1'b1;
			oeN_q      <= 1'b0;
		end else begin
			state_q    <= state_d;
			detCnt_q   <= detCnt_d;
			tickCnt_q  <= tickCnt_d;
			time_q     <= time_d;
			kickDly_q  <= kickInput;
			rstStrap_q <= rstStrap_d;
			winStrap_q <= winStrap_d;
			pd_q       <= pd_d;
			chg_q      <= chg_d;
			fault_q    <= fault_d;
			done_q     <= done_d;
			pdOut_q    <= pdOut_d;
			oeN_q      <= oeN_d;
		end
	end

	always_comb begin
		resetDelayPulldown = pdOut_q; // Discharge while held
		resetDelayCharge   = chg_q;
		windowTimePulldown = pd_q;
		faultOutput_n      = 1'b0;
		faultOutputOe_n    = oeN_q; // Open drain: enable low pulls the pin
		detectDone         = done_q;
	end

	property p_detect_bound;
		@(posedge clk) disable iff (srst)
		(state_q == ST_DETECT && detCnt_q == DETECT_CYCLES - 1) |=> state_q == ST_LOAD;
	endproperty
	a_detect_bound: assert property (p_detect_bound) else $error("detect overrun");

	property p_refault;
		@(posedge clk) disable iff (srst)
		$rose(fault_q) |-> state_q == ST_DETECT && detCnt_q == 0;
	endproperty
	a_refault: assert property (p_refault) else $error("no redetect on fault");

	property p_off_quiet;
		@(posedge clk) disable iff (srst)
		(state_q == ST_OFF) |=> !fault_q && state_q == ST_OFF;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("disabled watchdog faulted");

	property p_no_count;
		@(posedge clk) disable iff (srst)
		(state_q == ST_DETECT) |-> !chg_q;
	endproperty
	a_no_count: assert property (p_no_count) else $error("counting during detect");

	property p_fault_hold;
		@(posedge clk) disable iff (srst)
		(state_q == ST_FAULT && kickFall && time_q > 1) |=> fault_q;
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("kick released fault");

	sequence s_late;
		state_q == ST_WINDOW && time_q == 0 && !kickFall && !cfg.disabled;
	endsequence
	property p_late;
		@(posedge clk) disable iff (srst)
		s_late |=> fault_q;
	endproperty
	a_late: assert property (p_late) else $error("late kick missed");

	property p_discharge;
		@(posedge clk) disable iff (srst)
		(fault_q && !chg_q) |-> resetDelayPulldown;
	endproperty
	a_discharge: assert property (p_discharge) else $error("no discharge in fault");

	property p_latch;
		@(posedge clk) disable iff (srst)
		(state_q == ST_WINDOW && $stable(state_q)) |-> $stable(cfg.upperTicks);
	endproperty
	a_latch: assert property (p_latch) else $error("timing changed without reset");

	property p_detect_pd;
		@(posedge clk) disable iff (srst)
		(state_q == ST_DETECT && detCnt_q != 0) |-> resetDelayPulldown && windowTimePulldown;
	endproperty
	a_detect_pd: assert property (p_detect_pd) else $error("pulldown off during detect");

	property p_first_kick;
		@(posedge clk) disable iff (srst)
		(state_q == ST_FIRST && kickFall && !cfg.disabled) |=> state_q == ST_WINDOW && time_q == cfg.upperTicks;
	endproperty
	a_first_kick: assert property (p_first_kick) else $error("first kick not accepted");

	sequence s_early;
		state_q == ST_WINDOW && kickFall && time_q > cfg.upperTicks - cfg.lowerTicks;
	endsequence
	property p_early;
		@(posedge clk) disable iff (srst)
		s_early |=> fault_q && state_q == ST_DETECT;
	endproperty
	a_early: assert property (p_early) else $error("early kick missed");

	property p_charge;
		@(posedge clk) disable iff (srst)
		(state_q == ST_FAULT && !chg_q) |=> resetDelayCharge && time_q == cfg.delayTicks;
	endproperty
	a_charge: assert property (p_charge) else $error("charge phase not started");

	sequence s_count_done;
		state_q == ST_FAULT && chg_q && rstStrap_q != STRAP_CAP && time_q == 0;
	endsequence
	property p_count_release;
		@(posedge clk) disable iff (srst)
		s_count_done |=> !fault_q && state_q == ST_FIRST;
	endproperty
	a_count_release: assert property (p_count_release) else $error("factory delay not released");

	sequence s_cap_done;
		state_q == ST_FAULT && chg_q && rstStrap_q == STRAP_CAP && resetDelayPinCharged;
	endsequence
	property p_cap_release;
		@(posedge clk) disable iff (srst)
		s_cap_done |=> !fault_q && !resetDelayCharge;
	endproperty
	a_cap_release: assert property (p_cap_release) else $error("threshold did not release");

	property p_fault_pin;
		@(posedge clk) disable iff (srst)
		fault_q |-> !faultOutputOe_n && !faultOutput_n;
	endproperty
	a_fault_pin: assert property (p_fault_pin) else $error("fault not on pin");
endmodule
`default_nettype wire

/* bench/wwts_far_side.sv */
`default_nettype none
module wwts_far_side
	import wwts_pkg::*;
#(
	parameter int CHARGE_CYCLES = 50
)(
	input  wire logic        clk,
	input  wire wwts_strap_t rstStrap,
	input  wire wwts_strap_t winStrap,
	input  wire logic        resetDelayPulldown,
	input  wire logic        resetDelayCharge,
	input  wire logic        windowTimePulldown,
	input  wire logic        faultOutput_n,
	input  wire logic        faultOutputOe_n,
	output logic             resetDelayPinIn,
	output logic             resetDelayPinCharged,
	output logic             windowTimePinIn,
	output logic             windowTimePinCharged,
	output logic      [23:0] resetDelayCapUs,
	output logic      [23:0] windowCapUs,
	output logic             faultLevel,
	output var logic         kickInput
);
	timeunit 1ns;
	timeprecision 1ps;
	int chargeCnt = 0;
	// A 10 kOhm pull-up beats the weak pulldown; open and capacitor read low
	assign resetDelayPinIn = (rstStrap == STRAP_PULL);
	assign windowTimePinIn = (winStrap == STRAP_PULL);
	// Discharge restarts the charge time, so a short release cannot trip early
	always @(posedge clk) chargeCnt <= resetDelayCharge ? chargeCnt + 1 : 0;
	assign resetDelayPinCharged = (rstStrap == STRAP_CAP) && (windowTimePulldown || chargeCnt >= CHARGE_CYCLES);
	assign windowTimePinCharged = (winStrap == STRAP_CAP) && windowTimePulldown;
	// Capacitors stay inside the characterised span
	assign resetDelayCapUs = 24'h00_0064;
	assign windowCapUs     = 24'h00_000A;
	// Board pull-up: a released line reads high
	assign faultLevel = faultOutputOe_n ? 1'b1 : faultOutput_n;
	initial kickInput = 1'b1;
	task automatic kick();
		kickInput = 1'b0;
		repeat (2) @(negedge clk);
		kickInput = 1'b1;
	endtask
endmodule
`default_nettype wire

/* bench/window_watchdog_timing_select_test.sv */
`default_nettype none
module window_watchdog_timing_select_test;
	timeunit 1ns;
	timeprecision 1ps;
	import wwts_pkg::*;
	typedef struct {wwts_strap_t ws; logic s0; logic s1; int lo; int up; bit late;} wwts_row_t;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        sel0 = 1'b1;
	logic        sel1 = 1'b1;
	wwts_strap_t rs = STRAP_CAP;
	wwts_strap_t ws = STRAP_OPEN;
	logic        kick, rPin, rChg, wPin, wChg, rPd, rCh, wPd, fN, fOe, done, fLvl, sawCharge;
	logic [23:0] rCap, wCap;
	int          errCount = 0;
	int          checked = 0;
	int          cycles = 0;
	int          n;
	int          lowCnt;
	wwts_row_t   rows[3] = '{'{STRAP_OPEN, 1'b0, 1'b1, OPEN_L01_US, OPEN_U01_US, 1'b1},
		'{STRAP_PULL, 1'b1, 1'b1, PULL_L11_US, PULL_U11_US, 1'b1},
		'{STRAP_PULL, 1'b0, 1'b0, PULL_L00_US, PULL_U00_US, 1'b0}};

	wwts_watchdog #(.DETECT_CYCLES(20), .TICK_CYCLES(1)) dut (.clk(clk), .srst(srst), .kickInput(kick),
		.ratioSelect0(sel0), .ratioSelect1(sel1), .resetDelayPinIn(rPin), .resetDelayPinCharged(rChg),
		.windowTimePinIn(wPin), .windowTimePinCharged(wChg), .resetDelayCapUs(rCap), .windowCapUs(wCap),
		.resetDelayPulldown(rPd), .resetDelayCharge(rCh), .windowTimePulldown(wPd), .faultOutput_n(fN),
		.faultOutputOe_n(fOe), .detectDone(done));
	wwts_far_side far (.clk(clk), .rstStrap(rs), .winStrap(ws), .resetDelayPulldown(rPd),
		.resetDelayCharge(rCh), .windowTimePulldown(wPd), .faultOutput_n(fN), .faultOutputOe_n(fOe),
		.resetDelayPinIn(rPin), .resetDelayPinCharged(rChg), .windowTimePinIn(wPin),
		.windowTimePinCharged(wChg), .resetDelayCapUs(rCap), .windowCapUs(wCap), .faultLevel(fLvl),
		.kickInput(kick));

	initial begin
		forever #2.5 clk = ~clk;
	end
	// Ceiling sits above the longest planned run, about 90k cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 100000) begin
			errCount++;
			conclude();
		end
	end

	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", checked, errCount);
		if (errCount == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic chkBit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			errCount++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkRange(input int got, input int lo, input int hi);
		checked++;
		if (got < lo || got > hi) begin
			errCount++;
			$display("CHECK FAILED at %0t: got %h expected %h..%h", $time, got, lo, hi);
		end
	endtask
	task automatic restart(input wwts_strap_t r, input wwts_strap_t w, input logic a, input logic b);
		rs = r;
		ws = w;
		sel0 = a;
		sel1 = b;
		srst = 1'b1;
		cyc(16);
		srst = 1'b0;
	endtask
	task automatic waitRelease();
		n = 0;
		sawCharge = 1'b0;
		while (fOe !== 1'b1 && n < 12000) begin
			cyc(1);
			n++;
			if (rCh === 1'b1) sawCharge = 1'b1;
		end
	endtask

	initial begin
		@(negedge clk);
		restart(STRAP_CAP, STRAP_OPEN, 1'b1, 1'b1);
		cyc(2);
		chkBit(fLvl, 1'b0);
		chkBit(rPd, 1'b1);
		chkBit(wPd, 1'b1);
		chkBit(done, 1'b0);
		cyc(21);
		chkBit(done, 1'b1);
		chkBit(wPd, 1'b0);
		waitRelease();
		chkBit(sawCharge, 1'b1);
		$display("reset test done");
		foreach (rows[i]) begin
			restart(STRAP_CAP, rows[i].ws, rows[i].s0, rows[i].s1);
			waitRelease();
			far.kick();
			cyc(rows[i].lo - 10);
			far.kick();
			chkBit(fLvl, 1'b0);
			chkBit(wPd, 1'b1);
			waitRelease();
			far.kick();
			cyc(rows[i].lo + 6);
			far.kick();
			chkBit(fLvl, 1'b1);
			if (rows[i].late) begin
				cyc(rows[i].up - 12);
				chkBit(fLvl, 1'b1);
				cyc(14);
				chkBit(fLvl, 1'b0);
			end
			$display("window row %0d done", i);
		end
		// Selects move without a reset: the old, shorter lower bound must stay
		restart(STRAP_CAP, STRAP_OPEN, 1'b0, 1'b1);
		waitRelease();
		far.kick();
		sel1 = 1'b0;
		cyc(OPEN_L01_US + 6);
		far.kick();
		chkBit(fLvl, 1'b1);
		$display("latch test done");
		restart(STRAP_CAP, STRAP_PULL, 1'b1, 1'b0);
		waitRelease();
		lowCnt = 0;
		far.kick();
		cyc(1);
		far.kick();
		repeat (12000) begin
			cyc(1);
			if (fLvl !== 1'b1) lowCnt++;
		end
		chkRange(lowCnt, 0, 0);
		$display("disable test done");
		restart(STRAP_PULL, STRAP_OPEN, 1'b1, 1'b1);
		waitRelease();
		chkRange(n, RST_PULL_US + 20, RST_PULL_US + 40);
		$display("pull-up delay test done");
		conclude();
	end
endmodule
`default_nettype wire
